/* File: core/mlta_access.sv */
// software access port to the mac lookup table
//
// Overview of operation
// - seven-bit filter group key at index bits 22:16 feeds the hash.
// - first index bits 15:0 hold mac key bits 47:32 for hashing.
// - second index register holds mac key bits 31:0 for hashing.
// - direct mode indexes the table with second index bits 11:0 only.
// - after a search, control bits 29:16 show the count of valid entries.
// - software sets go bit 7; hardware clears it when the operation ends.
// - during search, bit 6 sets when the next valid entry is loaded.
// - reading byte 0x042f clears the next-entry-ready bit.
// - bit 5 reads one when an entry is ready or the search ended.
// - control bit 2 selects direct indexing; zero selects the hash.
// - action field 1:0: none, write, read, search.
// - entry data pass through four shared 32-bit entry registers.
// - entry registers sit at 0x0420 through 0x042f.
`timescale 1ns/100ps
module mlta_access #(
  parameter int IDX_W = mlta_pkg::IDX_W_DEFAULT
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire mlta_pkg::mlta_breq_t req,
  output logic [7:0] rdata,
  output logic rdata_valid
);

  generate
    if (IDX_W < 1 || IDX_W > mlta_pkg::HASH_BITS_MAX) begin : g_bad
      $error("index width out of range");
    end
  endgenerate

  typedef enum {MLTA_IDLE, MLTA_EXEC, MLTA_SCAN, MLTA_WAIT} mlta_state_t;

  localparam logic [IDX_W-1:0] LAST_IDX = '1;

  mlta_state_t state, next_state;
  mlta_pkg::mlta_upper_t upper, next_upper;
  logic [31:0] lower, next_lower;
  mlta_pkg::mlta_ctrl_lo_t ctrl, next_ctrl;
  logic [mlta_pkg::COUNT_W-1:0] count_res, next_count_res;
  logic [mlta_pkg::COUNT_W-1:0] run_cnt, next_run_cnt;
  logic [IDX_W-1:0] scan_idx, next_scan_idx;
  mlta_pkg::mlta_entry_t entry, next_entry;
  logic [7:0] next_rdata;
  logic next_rdata_valid;

  logic [IDX_W-1:0] calc_idx, tbl_idx;
  logic tbl_we, tbl_valid;
  mlta_pkg::mlta_entry_t tbl_rdata;
  mlta_pkg::mlta_ctrl_t ctrl_word;
  logic [15:0] waddr;
  logic [1:0] lane;
  logic [31:0] rd_word;
  logic last_byte_read;

  function automatic logic [IDX_W-1:0] hash_idx(
    input logic [6:0] key_fid,
    input logic [47:0] key_mac
  );
    logic [54:0] key;
    logic [IDX_W-1:0] h;
    key = {key_fid, key_mac};
    h = '0;
    for (int i = 0; i < 55; i++) begin
      h[i % IDX_W] = h[i % IDX_W] ^ key[i];
    end
    return h;
  endfunction : hash_idx

  function automatic logic [31:0] put_byte(
    input logic [31:0] w,
    input logic [1:0] ln,
    input logic [7:0] b
  );
    logic [31:0] r;
    r = w;
    r[{ln, 3'h0} +: 8] = b;
    return r;
  endfunction : put_byte

  function automatic logic [7:0] get_byte(
    input logic [31:0] w,
    input logic [1:0] ln
  );
    return w[{ln, 3'h0} +: 8];
  endfunction : get_byte

  mlta_table #(
    .IDX_W(IDX_W)
  ) u_table (
    .clock(clock),
    .rst_n(rst_n),
    .wr_en(tbl_we),
    .idx(tbl_idx),
    .wdata(entry),
    .rdata(tbl_rdata)
  );

  // index selection: hash or direct, or the scan index during a search
  always_comb begin
    if (ctrl.direct) begin
      calc_idx = lower[IDX_W-1:0];
    end else begin
      calc_idx = hash_idx(upper.filter_group_key,
                          {upper.mac_hi, lower});
    end
    if (state == MLTA_SCAN || state == MLTA_WAIT) begin
      tbl_idx = scan_idx;
    end else begin
      tbl_idx = calc_idx;
    end
    tbl_valid = |tbl_rdata;
  end

  // register read decode
  always_comb begin
    waddr = {req.addr[15:2], 2'h0};
    lane = req.addr[1:0];
    ctrl_word = '0;
    ctrl_word.valid_count = count_res;
    ctrl_word.lo = ctrl;
    ctrl_word.lo.ready_or_end = ctrl.ready | ctrl.ready_or_end;
    rd_word = '0;
    if (waddr == mlta_pkg::OFS_INDEX_UPPER) begin
      rd_word = upper;
    end else if (waddr == mlta_pkg::OFS_INDEX_LOWER) begin
      rd_word = lower;
    end else if (waddr == mlta_pkg::OFS_CONTROL) begin
      rd_word = ctrl_word;
    end else if (req.addr[15:4] == mlta_pkg::OFS_ENTRY_BASE[15:4]) begin
      rd_word = entry[req.addr[3:2]];
    end
    last_byte_read = req.rd && req.addr == mlta_pkg::ADDR_ENTRY_LAST;
  end

  // next values of the whole block
  always_comb begin
    next_state = state;
    next_upper = upper;
    next_lower = lower;
    next_ctrl = ctrl;
    next_count_res = count_res;
    next_run_cnt = run_cnt;
    next_scan_idx = scan_idx;
    next_entry = entry;
    next_rdata = req.rd ? get_byte(rd_word, lane) : 8'h00;
    next_rdata_valid = req.rd;
    tbl_we = 1'b0;
    if (last_byte_read) begin
      next_ctrl.ready = 1'b0;
    end
    case (state)
      MLTA_IDLE: begin
        if (req.wr) begin
          if (waddr == mlta_pkg::OFS_INDEX_UPPER) begin
            next_upper = put_byte(upper, lane, req.wdata)
                         & mlta_pkg::INDEX_UPPER_WMASK;
          end else if (waddr == mlta_pkg::OFS_INDEX_LOWER) begin
            next_lower = put_byte(lower, lane, req.wdata);
          end else if (req.addr == mlta_pkg::OFS_CONTROL) begin
            next_ctrl = req.wdata;
            next_ctrl.ready = ctrl.ready;
            next_ctrl.ready_or_end = 1'b0;
            if (next_ctrl.go_done_flag) begin
              if (next_ctrl.action == mlta_pkg::MLTA_ACT_SEARCH) begin
                next_state = MLTA_SCAN;
                next_scan_idx = '0;
                next_run_cnt = '0;
              end else begin
                next_state = MLTA_EXEC;
              end
            end
          end else if (req.addr[15:4] == mlta_pkg::OFS_ENTRY_BASE[15:4])
          begin
            next_entry[req.addr[3:2]] =
              put_byte(entry[req.addr[3:2]], lane, req.wdata);
          end
        end
      end
      MLTA_EXEC: begin
        case (ctrl.action)
          mlta_pkg::MLTA_ACT_WRITE: tbl_we = 1'b1;
          mlta_pkg::MLTA_ACT_READ: next_entry = tbl_rdata;
          default: next_entry = entry;
        endcase
        next_ctrl.go_done_flag = 1'b0;
        next_state = MLTA_IDLE;
      end
      MLTA_SCAN: begin
        if (tbl_valid) begin
          next_entry = tbl_rdata;
          next_ctrl.ready = 1'b1;
          next_run_cnt = mlta_pkg::COUNT_W'(run_cnt + 1'b1);
          next_state = MLTA_WAIT;
        end else if (scan_idx == LAST_IDX) begin
          next_ctrl.ready_or_end = 1'b1;
          next_count_res = run_cnt;
          next_ctrl.go_done_flag = 1'b0;
          next_state = MLTA_IDLE;
        end else begin
          next_scan_idx = IDX_W'(scan_idx + 1'b1);
        end
      end
      MLTA_WAIT: begin
        if (last_byte_read) begin
          if (scan_idx == LAST_IDX) begin
            next_ctrl.ready_or_end = 1'b1;
            next_count_res = run_cnt;
            next_ctrl.go_done_flag = 1'b0;
            next_state = MLTA_IDLE;
          end else begin
            next_scan_idx = IDX_W'(scan_idx + 1'b1);
            next_state = MLTA_SCAN;
          end
        end
      end
      default: begin
        next_state = MLTA_IDLE;
      end
    endcase
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state <= MLTA_IDLE;
      upper <= '0;
      lower <= mlta_pkg::INDEX_LOWER_RESET;
      ctrl <= '0;
      count_res <= '0;
      run_cnt <= '0;
      scan_idx <= '0;
      entry <= '0;
      rdata <= 8'h00;
      rdata_valid <= 1'b0;
    end else begin
      state <= next_state;
      upper <= next_upper;
      lower <= next_lower;
      ctrl <= next_ctrl;
      count_res <= next_count_res;
      run_cnt <= next_run_cnt;
      scan_idx <= next_scan_idx;
      entry <= next_entry;
      rdata <= next_rdata;
      rdata_valid <= next_rdata_valid;
    end
  end

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_n);

  sequence s_start(mlta_pkg::mlta_act_t a);
    state == MLTA_IDLE && req.wr && req.addr == mlta_pkg::OFS_CONTROL
      && req.wdata[7] && req.wdata[1:0] == a;
  endsequence

  sequence s_last_read;
    req.rd && req.addr == mlta_pkg::ADDR_ENTRY_LAST;
  endsequence

  a_go_write_done: assert property (
    s_start(mlta_pkg::MLTA_ACT_WRITE) |=> ctrl.go_done_flag
      ##1 !ctrl.go_done_flag && state == MLTA_IDLE)
    else $error("write did not finish in two cycles");

  a_nop_done: assert property (
    s_start(mlta_pkg::MLTA_ACT_NOP) |=> state == MLTA_EXEC
      ##1 !ctrl.go_done_flag && entry == $past(entry))
    else $error("no-op changed entry or stuck");

  a_read_loads: assert property (
    state == MLTA_EXEC && ctrl.action == mlta_pkg::MLTA_ACT_READ
      |=> entry == $past(tbl_rdata))
    else $error("read did not load entry registers");

  a_write_stores: assert property (
    state == MLTA_EXEC && ctrl.action == mlta_pkg::MLTA_ACT_WRITE
      |=> tbl_rdata == $past(entry))
    else $error("write did not store entry");

  a_index_direct: assert property (
    state == MLTA_EXEC && ctrl.direct |-> tbl_idx == lower[IDX_W-1:0])
    else $error("direct index wrong");

  a_index_hash: assert property (
    state == MLTA_EXEC && !ctrl.direct |-> tbl_idx ==
      hash_idx(upper.filter_group_key, {upper.mac_hi, lower}))
    else $error("hash index wrong");

  a_found_ready: assert property (
    state == MLTA_SCAN && tbl_valid
      |=> ctrl.ready && ctrl.go_done_flag && entry == $past(tbl_rdata))
    else $error("found entry not presented");

  a_ready_clear: assert property (
    (s_last_read and !(state == MLTA_SCAN && tbl_valid)) |=> !ctrl.ready)
    else $error("ready not cleared by last byte read");

  a_combo_read: assert property (
    req.rd && req.addr == mlta_pkg::OFS_CONTROL
      |=> rdata_valid
      && rdata[5] == ($past(ctrl.ready) || $past(ctrl.ready_or_end)))
    else $error("combined flag wrong");

  a_count_final: assert property (
    state == MLTA_SCAN && !tbl_valid && scan_idx == LAST_IDX
      |=> count_res == $past(run_cnt) && !ctrl.go_done_flag
      && ctrl.ready_or_end)
    else $error("valid count not reported");

  a_entry_map: assert property (
    req.rd && req.addr == mlta_pkg::OFS_ENTRY_BASE
      |=> rdata == $past(entry[0][7:0]))
    else $error("entry register map wrong");

  a_scan_resume: assert property (
    state == MLTA_WAIT && last_byte_read && scan_idx != LAST_IDX
      |=> state == MLTA_SCAN && scan_idx == $past(scan_idx) + 1'b1)
    else $error("search did not resume");

endmodule : mlta_access

/* File: core/mlta_pkg.sv */
// shared constants and types for the lookup table access port
package mlta_pkg;

  localparam logic [15:0] OFS_INDEX_UPPER = 16'h0410;
  localparam logic [15:0] OFS_INDEX_LOWER = 16'h0414;
  localparam logic [15:0] OFS_CONTROL = 16'h0418;
  localparam logic [15:0] OFS_ENTRY_BASE = 16'h0420;
  localparam logic [15:0] ADDR_ENTRY_LAST = 16'h042f;
  localparam int ENTRY_WORDS = 4;
  localparam int HASH_BITS_MAX = 12;
  localparam int COUNT_W = 14;
  localparam int IDX_W_DEFAULT = 12;
  localparam logic [31:0] INDEX_UPPER_WMASK = 32'h807f_ffff;
  localparam logic [31:0] INDEX_LOWER_RESET = 32'h0000_0000;

  typedef enum logic [1:0] {
    MLTA_ACT_NOP = 2'h0,
    MLTA_ACT_WRITE = 2'h1,
    MLTA_ACT_READ = 2'h2,
    MLTA_ACT_SEARCH = 2'h3
  } mlta_act_t;

  // byte access request, one strobe per cycle
  typedef struct packed {
    logic wr;
    logic rd;
    logic [15:0] addr;
    logic [7:0] wdata;
  } mlta_breq_t;

  // first index register layout
  typedef struct packed {
    logic rsv_rw;
    logic [7:0] rsv_ro;
    logic [6:0] filter_group_key;
    logic [15:0] mac_hi;
  } mlta_upper_t;

  // low byte of the control register
  typedef struct packed {
    logic go_done_flag;
    logic ready;
    logic ready_or_end;
    logic [1:0] rsv_rw;
    logic direct;
    mlta_act_t action;
  } mlta_ctrl_lo_t;

  typedef struct packed {
    logic [1:0] rsv_hi;
    logic [COUNT_W-1:0] valid_count;
    logic [7:0] rsv_mid;
    mlta_ctrl_lo_t lo;
  } mlta_ctrl_t;

  typedef logic [ENTRY_WORDS-1:0][31:0] mlta_entry_t;

endpackage : mlta_pkg

/* File: core/mlta_table.sv */
// lookup table storage, flip-flops addressed by index
`timescale 1ns/100ps
module mlta_table #(
  parameter int IDX_W = mlta_pkg::IDX_W_DEFAULT
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic wr_en,
  input wire logic [IDX_W-1:0] idx,
  input wire mlta_pkg::mlta_entry_t wdata,
  output mlta_pkg::mlta_entry_t rdata
);

  mlta_pkg::mlta_entry_t mem [2**IDX_W];
  mlta_pkg::mlta_entry_t next_mem [2**IDX_W];

  always_comb begin
    next_mem = mem;
    if (wr_en) begin
      next_mem[idx] = wdata;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < 2**IDX_W; i++) begin
        mem[i] <= '0;
      end
    end else begin
      mem <= next_mem;
    end
  end

  assign rdata = mem[idx];

endmodule : mlta_table

/* File: verif/test_mac_lookup_table_access.sv */
// self-checking bench for the lookup table access port
`timescale 1ns/100ps
module test_mac_lookup_table_access;
  localparam int IW = 3;
  localparam logic [15:0] A_UP = mlta_pkg::OFS_INDEX_UPPER;
  localparam logic [15:0] A_LO = mlta_pkg::OFS_INDEX_LOWER;
  localparam logic [15:0] A_CTL = mlta_pkg::OFS_CONTROL;
  localparam logic [15:0] A_ENT = mlta_pkg::OFS_ENTRY_BASE;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  mlta_pkg::mlta_breq_t req = '0;
  logic [7:0] rdata;
  logic rdata_valid;
  int error_cnt = 0;
  int checks_done = 0;
  logic [7:0] b;
  logic [31:0] w;
  logic [127:0] d_dir;
  logic [127:0] d_hsh;
  logic [IW-1:0] h;

  mlta_access #(.IDX_W(IW)) DUT (
    .clock(clock),
    .rst_n(rst_n),
    .req(req),
    .rdata(rdata),
    .rdata_valid(rdata_valid)
  );

  always #5 clock = ~clock;

  task automatic stop_test;
    $display("checks %0d, mismatches %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : stop_test

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic wr_b(input logic [15:0] a, input logic [7:0] d);
    @(negedge clock);
    req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(negedge clock);
    req.wr = 1'b0;
  endtask : wr_b

  task automatic rd_b(input logic [15:0] a, output logic [7:0] d);
    @(negedge clock);
    req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(negedge clock);
    req.rd = 1'b0;
    chk({31'h0, rdata_valid}, 32'h1);
    d = rdata;
  endtask : rd_b

  task automatic wr_w(input logic [15:0] a, input logic [31:0] d);
    for (int i = 0; i < 4; i++) wr_b(a + 16'(i), d[8*i +: 8]);
  endtask : wr_w

  task automatic rd_w(input logic [15:0] a, output logic [31:0] d);
    logic [7:0] t;
    for (int i = 0; i < 4; i++) begin
      rd_b(a + 16'(i), t);
      d[8*i +: 8] = t;
    end
  endtask : rd_w

  task automatic wr_e(input logic [127:0] d);
    for (int i = 0; i < 4; i++) wr_w(A_ENT + 16'(4 * i), d[32*i +: 32]);
  endtask : wr_e

  task automatic chk_e(input logic [127:0] e);
    for (int i = 0; i < 4; i++) begin
      rd_w(A_ENT + 16'(4 * i), w);
      chk(w, e[32*i +: 32]);
    end
  endtask : chk_e

  task automatic wait_ctl(input logic [7:0] m, input logic [7:0] v);
    for (int n = 0; n < 200; n++) begin
      rd_b(A_CTL, b);
      if ((b & m) === v) return;
    end
    error_cnt++;
    $display("wrong value at %0t: got %h expected %h", $time, b & m, v);
    stop_test();
  endtask : wait_ctl

  task automatic op(input logic [7:0] c);
    wr_b(A_CTL, c);
    wait_ctl(8'h80, 8'h00);
  endtask : op

  // key bit i folds into slot bit i mod IW
  function automatic logic [IW-1:0] fold(input logic [54:0] k);
    logic [IW-1:0] r;
    r = '0;
    for (int i = 0; i < 55; i++) r[i % IW] = r[i % IW] ^ k[i];
    return r;
  endfunction : fold

  initial begin
    repeat (20) @(negedge clock);
    rst_n = 1'b1;
    rd_b(A_CTL, b);
    chk(b, 8'h00);
    rd_w(A_LO, w);
    chk(w, mlta_pkg::INDEX_LOWER_RESET);
    rd_b(16'h0440, b);
    chk(b, 8'h00);
    $display("reset test done");
    wr_w(A_UP, 32'hffff_ffff);
    rd_w(A_UP, w);
    chk(w, 32'h807f_ffff);
    $display("index test done");
    d_dir = 128'h0123_4567_89ab_cdef_fedc_ba98_7654_3210;
    wr_w(A_LO, 32'habcd_0ffd);
    wr_e(d_dir);
    op(8'h9d);
    rd_b(A_CTL, b);
    chk(b, 8'h1d);
    wr_e('0);
    op(8'h86);
    chk_e(d_dir);
    $display("direct test done");
    d_hsh = 128'h5a5a_0001_c3c3_0002_9696_0003_e1e1_0004;
    wr_w(A_UP, 32'h0002_8000);
    wr_w(A_LO, 32'h0000_0008);
    h = fold({7'h02, 48'h8000_0000_0008});
    wr_e(d_hsh);
    op(8'h81);
    wr_e('0);
    op(8'h82);
    chk_e(d_hsh);
    op(8'h80);
    chk_e(d_hsh);
    wr_w(A_LO, 32'(h));
    wr_e('0);
    op(8'h86);
    chk_e(d_hsh);
    $display("hash test done");
    wr_b(A_CTL, 8'h83);
    wait_ctl(8'h60, 8'h60);
    wr_b(A_LO, 8'haa);
    chk_e(h < 3'h5 ? d_hsh : d_dir);
    wait_ctl(8'h60, 8'h60);
    chk_e(h < 3'h5 ? d_dir : d_hsh);
    wait_ctl(8'he0, 8'h20);
    rd_b(A_CTL + 16'h0002, b);
    chk(b, 8'h02);
    rd_b(A_CTL + 16'h0003, b);
    chk(b, 8'h00);
    rd_b(A_LO, b);
    chk(b, 8'(h));
    $display("search test done");
    stop_test();
  end
endmodule : test_mac_lookup_table_access
